// ===== bench/test_return_and_reset_ops.sv
`default_nettype none
module test_return_and_reset_ops
	import rro_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// Stimulus
	logic ref_clk, nrst, op_valid, soft_reset_flag_set;
	rro_op_t op_sel;
	logic [7:0] op_literal;
	logic [RRO_PC_W-1:0] stack_top_entry;
	logic [2:0] status_flags_in;
	// Observed results
	logic busy, stack_pop, pc_load, acc_load, global_irq_allow, soft_reset_flag, device_reset_req;
	logic [RRO_PC_W-1:0] instruction_pointer;
	logic [7:0] acc_value, irq_control_reg;
	logic [2:0] status_flags_out;
	int failures, checked;

	rro_exec dut (.ref_clk(ref_clk), .nrst(nrst), .op_valid(op_valid), .op_sel(op_sel),
		.op_literal(op_literal), .stack_top_entry(stack_top_entry),
		.status_flags_in(status_flags_in), .soft_reset_flag_set(soft_reset_flag_set),
		.busy(busy), .stack_pop(stack_pop), .pc_load(pc_load),
		.instruction_pointer(instruction_pointer), .acc_load(acc_load), .acc_value(acc_value),
		.irq_control_reg(irq_control_reg), .global_irq_allow(global_irq_allow),
		.status_flags_out(status_flags_out), .soft_reset_flag(soft_reset_flag),
		.device_reset_req(device_reset_req));

	// 25 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Compare and count
	task automatic chk(input logic [14:0] seen, input logic [14:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		if (failures == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// One request, op_valid held for hold edges; returns just after the last
	task automatic req(input rro_op_t op, input logic [7:0] k, input logic [14:0] top,
		input logic [2:0] fl, input int hold);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_sel <= op;
		op_literal <= k;
		stack_top_entry <= top;
		status_flags_in <= fl;
		repeat (hold) @(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
	endtask : req

	// Literal return at a literal boundary
	task automatic lit_ret(input logic [7:0] k, input logic [14:0] top);
		req(RRO_OP_LIT_RETURN, k, top, 3'h5, 1);
		chk(15'(acc_load), 15'h1);
		chk(15'(acc_value), 15'(k));
		chk(15'(stack_pop), 15'h1);
		chk(15'(busy), 15'h1);
		@(posedge ref_clk) #1;
		chk(15'(pc_load), 15'h1);
		chk(15'(busy), 15'h0);
		chk(instruction_pointer, top);
		chk(15'(status_flags_out), 15'h5);
	endtask : lit_ret

	// Interrupt return leaves the accumulator alone
	task automatic irq_ret(input logic [14:0] top, input logic [7:0] acc_exp);
		chk(15'(global_irq_allow), 15'h0);
		req(RRO_OP_IRQ_RETURN, 8'h3c, top, 3'h2, 1);
		chk(15'(stack_pop), 15'h1);
		chk(15'(acc_load), 15'h0);
		chk(15'(global_irq_allow), 15'h1);
		chk(15'(irq_control_reg), 15'h80);
		@(posedge ref_clk) #1;
		chk(15'(pc_load), 15'h1);
		chk(instruction_pointer, top);
		chk(15'(acc_value), 15'(acc_exp));
		chk(15'(status_flags_out), 15'h2);
	endtask : irq_ret

	// Idle op, then a request repeated while busy
	task automatic refused;
		req(RRO_OP_NONE, 8'h11, 15'h0123, 3'h5, 1);
		chk(15'(stack_pop), 15'h0);
		chk(15'(busy), 15'h0);
		req(RRO_OP_LIT_RETURN, 8'h5a, 15'h0456, 3'h5, 2);
		chk(15'(pc_load), 15'h1);
		chk(instruction_pointer, 15'h0456);
		@(posedge ref_clk) #1;
		chk(15'(stack_pop), 15'h0);
		chk(15'(acc_load), 15'h0);
	endtask : refused

	// Software reset pulse and flag clear, then flag set by other logic
	task automatic soft_rst;
		chk(15'(soft_reset_flag), 15'h1);
		req(RRO_OP_SOFT_RESET, 8'h00, 15'h0000, 3'h5, 1);
		chk(15'(soft_reset_flag), 15'h0);
		chk(15'(device_reset_req), 15'h0);
		repeat (2) begin
			@(posedge ref_clk) #1;
			chk(15'(device_reset_req), 15'h1);
		end
		@(posedge ref_clk) #1;
		chk(15'(device_reset_req), 15'h0);
		@(posedge ref_clk);
		soft_reset_flag_set <= 1'b1;
		@(posedge ref_clk);
		soft_reset_flag_set <= 1'b0;
		#1;
		chk(15'(soft_reset_flag), 15'h1);
		// Set from other logic in the same cycle as the op wins
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_sel <= RRO_OP_SOFT_RESET;
		soft_reset_flag_set <= 1'b1;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		soft_reset_flag_set <= 1'b0;
		#1;
		chk(15'(soft_reset_flag), 15'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(15'(device_reset_req), 15'h1);
	endtask : soft_rst

	// Reset in mid-run brings back the reset state
	task automatic hard_rst;
		@(posedge ref_clk);
		nrst <= 1'b0;
		#1;
		chk(15'(irq_control_reg), 15'(RRO_IRQ_CTRL_RST));
		chk(15'(acc_value), 15'(RRO_ACC_RST));
		chk(instruction_pointer, 15'h0000);
		chk(15'(soft_reset_flag), 15'(RRO_SOFT_RESET_FLAG_RST));
		chk(15'(busy), 15'h0);
		chk(15'(device_reset_req), 15'h0);
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
	endtask : hard_rst

	// Main sequence
	initial begin
		failures = 0;
		checked = 0;
		nrst = 1'b0;
		op_valid = 1'b0;
		op_sel = RRO_OP_NONE;
		op_literal = 8'h00;
		stack_top_entry = 15'h0000;
		status_flags_in = 3'h5;
		soft_reset_flag_set = 1'b0;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		lit_ret(8'h00, 15'h7fff);
		lit_ret(8'hff, 15'h0001);
		irq_ret(15'h2a55, 8'hff);
		refused;
		soft_rst;
		hard_rst;
		irq_ret(15'h1357, RRO_ACC_RST);
		lit_ret(8'h81, 15'h4000);
		tally_and_finish;
	end

	// Watchdog
	initial begin
		#20000;
		failures++;
		tally_and_finish;
	end
endmodule : test_return_and_reset_ops
`default_nettype wire

// ===== src/rro_exec.sv
// Behaviour
// - Software reset op raises a two-cycle device reset request
// - Software reset op clears soft reset flag
// - Interrupt return pops stack into pointer, two cycles
// - Interrupt return sets global interrupt allow bit
// - Literal return writes 8-bit literal to accumulator
// - Literal return loads pointer from stack top
`default_nettype none
module rro_exec
	import rro_pkg::*;
#(
	parameter int PC_W = RRO_PC_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Decoder request, held one cycle
	input wire logic op_valid,
	input wire rro_op_t op_sel,
	input wire logic [7:0] op_literal,
	// Return stack side
	input wire logic [PC_W-1:0] stack_top_entry,
	// Current arithmetic status flags
	input wire logic [2:0] status_flags_in,
	// Soft reset flag written by other logic
	input wire logic soft_reset_flag_set,
	// Results
	output logic busy,
	output logic stack_pop,
	output logic pc_load,
	output logic [PC_W-1:0] instruction_pointer,
	output logic acc_load,
	output logic [7:0] acc_value,
	output logic [7:0] irq_control_reg,
	output logic global_irq_allow,
	output logic [2:0] status_flags_out,
	output logic soft_reset_flag,
	output logic device_reset_req
);
	typedef enum {
		RRO_IDLE,
		RRO_RET2
	} rro_fsm_t;

	typedef struct packed {
		rro_fsm_t fsm;
		logic busy;
		logic pop;
		logic pc_load;
		logic [PC_W-1:0] ip;
		logic acc_load;
		logic [7:0] acc;
		logic [7:0] irq_ctrl;
		logic [2:0] flags;
		logic srf;
		logic srst_trig;
	} rro_state_t;

	rro_state_t st_reg;
	rro_state_t st_next;
	logic srst_pulse;

	// Is the request a two-cycle return op
	function automatic logic is_return(input rro_op_t op);
		return (op == RRO_OP_IRQ_RETURN) || (op == RRO_OP_LIT_RETURN);
	endfunction : is_return

	// Sequencing and architectural updates
	always_comb begin
		st_next = st_reg;
		st_next.pop = 1'b0;
		st_next.pc_load = 1'b0;
		st_next.acc_load = 1'b0;
		st_next.srst_trig = 1'b0;
		st_next.flags = status_flags_in;
		case (st_reg.fsm)
			RRO_IDLE: begin
				st_next.busy = 1'b0;
				if (op_valid) begin
					if (op_sel == RRO_OP_SOFT_RESET) begin
						st_next.srst_trig = 1'b1;
						st_next.srf = 1'b0;
					end else if (is_return(op_sel)) begin
						st_next.fsm = RRO_RET2;
						st_next.busy = 1'b1;
						st_next.pop = 1'b1;
						if (op_sel == RRO_OP_IRQ_RETURN) begin
							st_next.irq_ctrl[RRO_IRQ_ALLOW_POS] = 1'b1;
						end else begin
							st_next.acc = op_literal;
							st_next.acc_load = 1'b1;
						end
					end
				end
			end
			RRO_RET2: begin
				// Second cycle commits popped entry
				st_next.ip = stack_top_entry;
				st_next.pc_load = 1'b1;
				st_next.busy = 1'b0;
				st_next.fsm = RRO_IDLE;
			end
			default: begin
				st_next.fsm = RRO_IDLE;
			end
		endcase
		// Set from other logic wins over a same-cycle clear
		if (soft_reset_flag_set) begin
			st_next.srf = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '{fsm: RRO_IDLE, busy: 1'b0, pop: 1'b0, pc_load: 1'b0,
				ip: '0, acc_load: 1'b0, acc: RRO_ACC_RST, irq_ctrl: RRO_IRQ_CTRL_RST,
				flags: 3'h0, srf: RRO_SOFT_RESET_FLAG_RST, srst_trig: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	// Reset pulse stretcher
	rro_srst_gen u_srst (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.trigger(st_reg.srst_trig),
		.srst_pulse(srst_pulse)
	);

	// Register outputs
	assign busy = st_reg.busy;
	assign stack_pop = st_reg.pop;
	assign pc_load = st_reg.pc_load;
	assign instruction_pointer = st_reg.ip;
	assign acc_load = st_reg.acc_load;
	assign acc_value = st_reg.acc;
	assign irq_control_reg = st_reg.irq_ctrl;
	assign global_irq_allow = st_reg.irq_ctrl[RRO_IRQ_ALLOW_POS];
	assign status_flags_out = st_reg.flags;
	assign soft_reset_flag = st_reg.srf;
	assign device_reset_req = srst_pulse;

	// Checks
	sequence s_ret_req;
		op_valid && !busy && is_return(op_sel);
	endsequence

	sequence s_srst_req;
		op_valid && !busy && op_sel == RRO_OP_SOFT_RESET;
	endsequence

	property p_srst;
		@(posedge ref_clk) disable iff (!nrst)
		(op_valid && !busy && op_sel == RRO_OP_SOFT_RESET) |-> ##2 device_reset_req [*2];
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset pulse missing");

	property p_srf;
		@(posedge ref_clk) disable iff (!nrst)
		(op_valid && !busy && op_sel == RRO_OP_SOFT_RESET && !soft_reset_flag_set)
			|=> !soft_reset_flag;
	endproperty
	a_srf: assert property (p_srf) else $error("soft reset flag not cleared");

	property p_pop;
		@(posedge ref_clk) disable iff (!nrst)
		s_ret_req |=> stack_pop && busy ##1 pc_load && !busy;
	endproperty
	a_pop: assert property (p_pop) else $error("return timing wrong");

	property p_pc;
		@(posedge ref_clk) disable iff (!nrst)
		(busy) |=> instruction_pointer == $past(stack_top_entry);
	endproperty
	a_pc: assert property (p_pc) else $error("pointer not loaded from stack");

	property p_irq_allow;
		@(posedge ref_clk) disable iff (!nrst)
		(op_valid && !busy && op_sel == RRO_OP_IRQ_RETURN) |=> global_irq_allow;
	endproperty
	a_irq_allow: assert property (p_irq_allow) else $error("interrupt allow not set");

	property p_lit;
		@(posedge ref_clk) disable iff (!nrst)
		(op_valid && !busy && op_sel == RRO_OP_LIT_RETURN)
			|=> acc_load && acc_value == $past(op_literal);
	endproperty
	a_lit: assert property (p_lit) else $error("literal not in accumulator");

	property p_flags;
		@(posedge ref_clk) disable iff (!nrst)
		nrst |=> status_flags_out == $past(status_flags_in);
	endproperty
	a_flags: assert property (p_flags) else $error("status flags altered");

	property p_acc_hold;
		@(posedge ref_clk) disable iff (!nrst)
		!(op_valid && !busy && op_sel == RRO_OP_LIT_RETURN) |=> $stable(acc_value);
	endproperty
	a_acc_hold: assert property (p_acc_hold) else $error("accumulator changed");

	property p_srf_set;
		@(posedge ref_clk) disable iff (!nrst)
		soft_reset_flag_set |=> soft_reset_flag;
	endproperty
	a_srf_set: assert property (p_srf_set) else $error("soft reset flag not set");

	property p_srst_quiet;
		@(posedge ref_clk) disable iff (!nrst)
		s_srst_req |=> !stack_pop && !busy && !acc_load;
	endproperty
	a_srst_quiet: assert property (p_srst_quiet) else $error("soft reset began a return");

	property p_busy_refuse;
		@(posedge ref_clk) disable iff (!nrst)
		busy |=> !stack_pop && !acc_load && !busy;
	endproperty
	a_busy_refuse: assert property (p_busy_refuse) else $error("request taken while busy");

	property p_none_op;
		@(posedge ref_clk) disable iff (!nrst)
		(op_valid && !busy && op_sel == RRO_OP_NONE) |=> !stack_pop && !busy && !pc_load;
	endproperty
	a_none_op: assert property (p_none_op) else $error("idle op started a return");

	property p_ip_hold;
		@(posedge ref_clk) disable iff (!nrst)
		!busy |=> $stable(instruction_pointer);
	endproperty
	a_ip_hold: assert property (p_ip_hold) else $error("pointer changed outside a return");
endmodule : rro_exec
`default_nettype wire

// ===== src/rro_pkg.sv
`default_nettype none
package rro_pkg;
	// Datapath widths
	localparam int RRO_PC_W = 15;
	localparam int RRO_DATA_W = 8;
	// Bit position of the global interrupt allow bit in the interrupt control register
	localparam int RRO_IRQ_ALLOW_POS = 7;
	// Execution lengths in instruction cycles
	localparam int RRO_RET_CYCLES = 2;
	localparam int RRO_OP_WORDS = 1;
	// Reset values
	localparam logic [7:0] RRO_IRQ_CTRL_RST = 8'h00;
	localparam logic [7:0] RRO_ACC_RST = 8'h00;
	localparam logic RRO_SOFT_RESET_FLAG_RST = 1'b1;
	// Length of the reset pulse raised by the software reset op
	localparam logic [1:0] RRO_SRST_CYCLES = 2'h2;
	// Decoded operation selector
	typedef enum logic [1:0] {
		RRO_OP_NONE,
		RRO_OP_SOFT_RESET,
		RRO_OP_IRQ_RETURN,
		RRO_OP_LIT_RETURN
	} rro_op_t;
endpackage : rro_pkg
`default_nettype wire

// ===== src/rro_srst_gen.sv
`default_nettype none
module rro_srst_gen
	import rro_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Trigger and pulse
	input wire logic trigger,
	output logic srst_pulse
);
	typedef struct packed {
		logic [1:0] cnt;
		logic pulse;
	} rro_srst_state_t;

	rro_srst_state_t st_reg;
	rro_srst_state_t st_next;

	// Stretch trigger into a fixed reset pulse
	always_comb begin
		st_next = st_reg;
		if (trigger) begin
			st_next.cnt = RRO_SRST_CYCLES;
		end else if (st_reg.cnt != 2'h0) begin
			st_next.cnt = st_reg.cnt - 2'h1;
		end
		st_next.pulse = trigger || (st_reg.cnt > 2'h1);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign srst_pulse = st_reg.pulse;
endmodule : rro_srst_gen
`default_nettype wire
